// File: include/sss_pkg.sv
// Shared constants and types for the serial slave unit with buffer engine.
// Assumes a single 100 MHz clock domain; pins are synchronised inside.
package sss_pkg;
   localparam int ADDR_W = 32;
   localparam int BYTE_W = 8;
   localparam int LIM_W = 14;
   // Largest byte limit that software may program.
   localparam logic [13:0] LIM_MAX = 14'h3FFF;
   localparam int FIFO_DEPTH = 32;
   localparam logic [13:0] CNT_RST = 14'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] PIN_IDLE = 3'h7;

   // One byte headed for the receive buffer.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } sss_wr_t;

   // Owner of the buffer pointers.
   typedef enum logic [1:0] {SEM_CPU, SEM_FREE, SEM_SLAVE} sss_sem_t;

   // Progress of one chip-select frame.
   typedef enum logic [1:0] {XF_IDLE, XF_GRANT, XF_IGNORE, XF_DRAIN} sss_xfer_t;
endpackage : sss_pkg

// File: logic/sss_spi_slave.sv
// Serial slave unit with semaphore-guarded buffer engine and write FIFO.
// Assumes a memory port that answers reads within a few clock cycles and
// a link clock more than ten times slower than mclk.
//
// Overview of operation
// - All four clock polarity and phase modes.
// - Bytes past transmit limit carry overrun fill.
// - Done event only after memory writes finish.
// - CPU grabs semaphore before changing pointers.
// - CPU gives semaphore back before slave takes it.
// - Give-back without ownership changes nothing.
// - Semaphore never blocks pointer or memory access.
// - Enabling gives CPU ownership without granted event.
// - Grab while CPU owns raises granted at once.
// - Failed take at select ignores whole frame.
// - Simultaneous requests award semaphore to CPU.
// - Granted frames store receive, send transmit bytes.
// - Deselect releases semaphore and raises done.
// - Free semaphore regrants frames with same pointers.
// - Shortcut hands semaphore to CPU after done.
// - Grab during slave ownership waits for release.
// - Shortcut plus pending grab serves one grab.
// - Excess received bytes set overflow, get dropped.
// - Excess read bytes set flag, send fill.
// - Done updates read and written byte counts.
// - Receive full event when limit reached.
// - Output enable low while not selected.
// - Byte limits programmable up to maximum field.

// Byte FIFO between the link and the memory write port.
module sss_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = sss_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [PW:0] cnt_r;
   logic push;
   logic pop;

   // Full and empty follow the occupancy count directly.
   assign in_ready = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage has no reset; only the pointers and the count need a defined value.
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Pointers wrap at a power-of-two depth.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : sss_fifo

// Top of the serial slave unit.
module sss_spi_slave #(
   parameter int LIM_W = sss_pkg::LIM_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic end_grab_shortcut,
   input wire logic task_grab,
   input wire logic task_give,
   input wire logic [sss_pkg::ADDR_W-1:0] rx_buffer_pointer,
   input wire logic [sss_pkg::ADDR_W-1:0] tx_buffer_pointer,
   input wire logic [LIM_W-1:0] rx_byte_limit,
   input wire logic [LIM_W-1:0] tx_byte_limit,
   input wire logic [7:0] overrun_fill_char,
   input wire logic [7:0] ignored_transaction_fill_char,
   input wire logic clr_overflow,
   input wire logic clr_tx_limit_exceeded_flag,
   input wire logic csn,
   input wire logic sck,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe,
   output logic sem_cpu_owned,
   output logic semaphore_granted_event,
   output logic transaction_done_event,
   output logic rx_buffer_full_event,
   output logic rx_overflow_flag,
   output logic tx_limit_exceeded_flag,
   output logic [LIM_W-1:0] rx_bytes_written_count,
   output logic [LIM_W-1:0] tx_bytes_read_count,
   output logic mem_rd_req,
   output logic [sss_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr_valid,
   output sss_pkg::sss_wr_t mem_wr,
   input wire logic mem_wr_ready
);
   logic [2:0] csn_q;
   logic [2:0] sck_q;
   logic [1:0] mosi_q;
   logic csn_fall, csn_rise, sel, lead, trail, smp_edge, drv_edge;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] tx_sh_r;
   logic [7:0] tx_buf_r;
   logic tx_valid_r;
   logic tx_fill_r;
   logic ld_pend_r;
   logic ld_go, need_mem, byte_done, grant_now, done_now, drained;
   logic [7:0] rx_byte;
   logic [7:0] byte_sel;
   sss_pkg::sss_sem_t sem_r;
   sss_pkg::sss_xfer_t xfer_r;
   logic grab_pend_r;
   logic [sss_pkg::ADDR_W-1:0] rx_ptr_r;
   logic [sss_pkg::ADDR_W-1:0] tx_ptr_r;
   logic [LIM_W-1:0] rx_lim_r;
   logic [LIM_W-1:0] tx_lim_r;
   logic [LIM_W-1:0] rx_cnt_r;
   logic [LIM_W-1:0] tx_cnt_r;
   logic wr_pend_r;
   sss_pkg::sss_wr_t wr_item_r;
   logic f_in_ready, f_out_valid, pop;
   sss_pkg::sss_wr_t f_out_data;

   // Byte address inside a buffer.
   function automatic logic [sss_pkg::ADDR_W-1:0] addr_at(
      input logic [sss_pkg::ADDR_W-1:0] base,
      input logic [LIM_W-1:0] idx);
      addr_at = base + sss_pkg::ADDR_W'(idx);
   endfunction : addr_at

   // Two flops before any logic; the third stage only serves edge finding.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         csn_q <= sss_pkg::PIN_IDLE;
         sck_q <= '0;
         mosi_q <= '0;
      end
      else
      begin
         csn_q <= {csn_q[1:0], csn};
         sck_q <= {sck_q[1:0], sck};
         mosi_q <= {mosi_q[0], mosi};
      end
   end

   // Leading edge leaves the idle level that the polarity selects.
   assign csn_fall = csn_q[2] & ~csn_q[1];
   assign csn_rise = ~csn_q[2] & csn_q[1];
   assign sel = ~csn_q[1];
   assign lead = cpol ? (sck_q[2] & ~sck_q[1]) : (~sck_q[2] & sck_q[1]);
   assign trail = cpol ? (~sck_q[2] & sck_q[1]) : (sck_q[2] & ~sck_q[1]);
   assign smp_edge = sel & (cpha ? trail : lead);
   assign drv_edge = sel & (cpha ? lead : trail);
   assign byte_done = smp_edge & (bit_cnt_r == sss_pkg::BIT_LAST);
   assign rx_byte = {rx_sh_r[6:0], mosi_q[1]};
   assign grant_now = csn_fall & enable & (xfer_r == sss_pkg::XF_IDLE)
                      & (sem_r == sss_pkg::SEM_FREE) & ~task_grab;
   assign need_mem = (xfer_r == sss_pkg::XF_GRANT) & (tx_cnt_r < tx_lim_r);
   assign ld_go = ld_pend_r & (~need_mem | tx_valid_r);
   assign drained = ~wr_pend_r & ~f_out_valid & ~mem_wr_valid;
   assign done_now = (xfer_r == sss_pkg::XF_DRAIN) & drained;
   assign pop = ~mem_wr_valid | mem_wr_ready;

   // Fill characters win whenever memory must not be read.
   always_comb
   begin
      if (xfer_r != sss_pkg::XF_GRANT)
      begin
         byte_sel = ignored_transaction_fill_char;
      end
      else if (need_mem)
      begin
         byte_sel = tx_buf_r;
      end
      else
      begin
         byte_sel = overrun_fill_char;
      end
   end

   // Receive shifter samples on the mode's sampling edge.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt_r <= sss_pkg::BIT_FIRST;
         rx_sh_r <= sss_pkg::BYTE_RST;
      end
      else if (csn_fall)
      begin
         bit_cnt_r <= sss_pkg::BIT_FIRST;
      end
      else if (smp_edge)
      begin
         rx_sh_r <= rx_byte;
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   // Phase 0 needs its first bit before any clock edge, so it loads at
   // select; phase 1 loads on the first leading edge of every byte.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ld_pend_r <= 1'b0;
         tx_sh_r <= sss_pkg::BYTE_RST;
         tx_fill_r <= 1'b0;
      end
      else
      begin
         if (csn_rise)
         begin
            ld_pend_r <= 1'b0;
         end
         else if ((csn_fall & ~cpha)
                  | (drv_edge & (bit_cnt_r == sss_pkg::BIT_FIRST)))
         begin
            ld_pend_r <= 1'b1;
         end
         else if (ld_go)
         begin
            ld_pend_r <= 1'b0;
         end
         if (ld_go)
         begin
            tx_sh_r <= byte_sel;
            tx_fill_r <= (xfer_r == sss_pkg::XF_GRANT) & ~need_mem;
         end
         else if (drv_edge & (bit_cnt_r != sss_pkg::BIT_FIRST))
         begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   // The pin is only driven while selected and enabled.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
      end
      else
      begin
         miso_o <= tx_sh_r[7];
         miso_oe <= enable & sel;
      end
   end

   // Frame sequencing; pointers and limits are frozen at the grant.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         xfer_r <= sss_pkg::XF_IDLE;
         rx_ptr_r <= '0;
         tx_ptr_r <= '0;
         rx_lim_r <= '0;
         tx_lim_r <= '0;
      end
      else
      begin
         case (xfer_r)
            sss_pkg::XF_IDLE:
            begin
               if (grant_now)
               begin
                  xfer_r <= sss_pkg::XF_GRANT;
                  rx_ptr_r <= rx_buffer_pointer;
                  tx_ptr_r <= tx_buffer_pointer;
                  rx_lim_r <= rx_byte_limit;
                  tx_lim_r <= tx_byte_limit;
               end
               else if (csn_fall & enable)
               begin
                  xfer_r <= sss_pkg::XF_IGNORE;
               end
            end
            sss_pkg::XF_GRANT:
            begin
               if (csn_rise)
               begin
                  xfer_r <= sss_pkg::XF_DRAIN;
               end
            end
            sss_pkg::XF_IGNORE:
            begin
               if (csn_rise)
               begin
                  xfer_r <= sss_pkg::XF_IDLE;
               end
            end
            sss_pkg::XF_DRAIN:
            begin
               if (drained)
               begin
                  xfer_r <= sss_pkg::XF_IDLE;
               end
            end
            default:
            begin
               xfer_r <= sss_pkg::XF_IDLE;
            end
         endcase
      end
   end

   // Semaphore owner; it reports ownership only and gates no access.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sem_r <= sss_pkg::SEM_CPU;
         grab_pend_r <= 1'b0;
         semaphore_granted_event <= 1'b0;
      end
      else
      begin
         semaphore_granted_event <= 1'b0;
         if (!enable)
         begin
            sem_r <= sss_pkg::SEM_CPU;
            grab_pend_r <= 1'b0;
         end
         else
         begin
            case (sem_r)
               sss_pkg::SEM_CPU:
               begin
                  if (task_grab)
                  begin
                     semaphore_granted_event <= 1'b1;
                  end
                  else if (task_give)
                  begin
                     sem_r <= sss_pkg::SEM_FREE;
                  end
               end
               sss_pkg::SEM_FREE:
               begin
                  if (task_grab)
                  begin
                     sem_r <= sss_pkg::SEM_CPU;
                     semaphore_granted_event <= 1'b1;
                  end
                  else if (grant_now)
                  begin
                     sem_r <= sss_pkg::SEM_SLAVE;
                  end
               end
               sss_pkg::SEM_SLAVE:
               begin
                  // A give-back here is ignored on purpose.
                  if (done_now)
                  begin
                     grab_pend_r <= 1'b0;
                     if (end_grab_shortcut | grab_pend_r | task_grab)
                     begin
                        sem_r <= sss_pkg::SEM_CPU;
                        semaphore_granted_event <= 1'b1;
                     end
                     else
                     begin
                        sem_r <= sss_pkg::SEM_FREE;
                     end
                  end
                  else if (task_grab)
                  begin
                     grab_pend_r <= 1'b1;
                  end
               end
               default:
               begin
                  sem_r <= sss_pkg::SEM_CPU;
               end
            endcase
         end
      end
   end

   // Transmit prefetch keeps the next buffer byte ready before its edge.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tx_cnt_r <= '0;
         tx_valid_r <= 1'b0;
         tx_buf_r <= sss_pkg::BYTE_RST;
         mem_rd_req <= 1'b0;
         mem_rd_addr <= '0;
      end
      else if (grant_now)
      begin
         tx_cnt_r <= '0;
         tx_valid_r <= 1'b0;
         mem_rd_req <= (tx_byte_limit != '0);
         mem_rd_addr <= tx_buffer_pointer;
      end
      else
      begin
         mem_rd_req <= 1'b0;
         if (mem_rd_valid & (xfer_r == sss_pkg::XF_GRANT))
         begin
            tx_buf_r <= mem_rd_data;
            tx_valid_r <= 1'b1;
         end
         if (ld_go & need_mem)
         begin
            tx_cnt_r <= tx_cnt_r + 1'b1;
            tx_valid_r <= 1'b0;
            if ((tx_cnt_r + 1'b1) < tx_lim_r)
            begin
               mem_rd_req <= 1'b1;
               mem_rd_addr <= addr_at(tx_ptr_r, tx_cnt_r + 1'b1);
            end
         end
      end
   end

   // Received bytes within the limit head for the FIFO; the rest drop.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rx_cnt_r <= '0;
         wr_pend_r <= 1'b0;
         wr_item_r <= '0;
         rx_buffer_full_event <= 1'b0;
      end
      else
      begin
         rx_buffer_full_event <= 1'b0;
         if (grant_now)
         begin
            rx_cnt_r <= '0;
         end
         if (wr_pend_r & f_in_ready)
         begin
            wr_pend_r <= 1'b0;
         end
         if (byte_done & (xfer_r == sss_pkg::XF_GRANT)
             & (rx_cnt_r < rx_lim_r))
         begin
            wr_pend_r <= 1'b1;
            wr_item_r <= '{addr: addr_at(rx_ptr_r, rx_cnt_r), data: rx_byte};
            rx_cnt_r <= rx_cnt_r + 1'b1;
            rx_buffer_full_event <= ((rx_cnt_r + 1'b1) == rx_lim_r);
         end
      end
   end

   // Sticky limit flags; a setting event beats a clear in the same cycle.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rx_overflow_flag <= 1'b0;
         tx_limit_exceeded_flag <= 1'b0;
      end
      else
      begin
         if (byte_done & (xfer_r == sss_pkg::XF_GRANT)
             & (rx_cnt_r >= rx_lim_r))
         begin
            rx_overflow_flag <= 1'b1;
         end
         else if (clr_overflow)
         begin
            rx_overflow_flag <= 1'b0;
         end
         // Set when the master clocks a fill byte's first bit, so a byte
         // loaded ahead of a deselect in phase 0 does not raise the flag.
         if (smp_edge & (bit_cnt_r == sss_pkg::BIT_FIRST) & tx_fill_r
             & (xfer_r == sss_pkg::XF_GRANT))
         begin
            tx_limit_exceeded_flag <= 1'b1;
         end
         else if (clr_tx_limit_exceeded_flag)
         begin
            tx_limit_exceeded_flag <= 1'b0;
         end
      end
   end

   // Completion reports counts only once memory writes have landed.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         transaction_done_event <= 1'b0;
         rx_bytes_written_count <= '0;
         tx_bytes_read_count <= '0;
         sem_cpu_owned <= 1'b1;
      end
      else
      begin
         transaction_done_event <= done_now;
         sem_cpu_owned <= (sem_r == sss_pkg::SEM_CPU);
         if (done_now)
         begin
            rx_bytes_written_count <= rx_cnt_r;
            tx_bytes_read_count <= tx_cnt_r;
         end
      end
   end

   // Output stage keeps the write port registered and stallable.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mem_wr_valid <= 1'b0;
         mem_wr <= '0;
      end
      else if (pop)
      begin
         mem_wr_valid <= f_out_valid;
         mem_wr <= f_out_data;
      end
   end

   sss_fifo #(.WIDTH($bits(sss_pkg::sss_wr_t)), .DEPTH(sss_pkg::FIFO_DEPTH))
   u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(wr_pend_r),
      .in_data(wr_item_r),
      .in_ready(f_in_ready),
      .out_valid(f_out_valid),
      .out_data(f_out_data),
      .out_ready(pop)
   );

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_held;
      grab_pend_r && !semaphore_granted_event && sem_r == sss_pkg::SEM_SLAVE;
   endsequence
   sequence s_served;
      semaphore_granted_event && sem_r == sss_pkg::SEM_CPU;
   endsequence

   a_give_ignored: assert property (
      (enable && sem_r == sss_pkg::SEM_SLAVE && task_give && !task_grab
       && !done_now) |=> sem_r == sss_pkg::SEM_SLAVE
       && !semaphore_granted_event)
      else $error("Give-back without ownership changed state.");
   a_grab_immediate: assert property (
      (enable && sem_r == sss_pkg::SEM_CPU && task_grab) |=> s_served)
      else $error("Grab while owned gave no granted event.");
   a_race_to_cpu: assert property (
      (enable && csn_fall && sem_r == sss_pkg::SEM_FREE && task_grab
       && xfer_r == sss_pkg::XF_IDLE)
      |=> sem_r == sss_pkg::SEM_CPU && xfer_r == sss_pkg::XF_IGNORE)
      else $error("Race not awarded to the processor.");
   a_enable_quiet: assert property (
      !enable |=> sem_r == sss_pkg::SEM_CPU && !semaphore_granted_event)
      else $error("Disabled slave left semaphore wrong.");
   a_done_drained: assert property (
      transaction_done_event |-> $past(drained)
      && !mem_wr_valid && !wr_pend_r)
      else $error("Done raised with writes outstanding.");
   a_grab_pending: assert property (
      (enable && sem_r == sss_pkg::SEM_SLAVE && task_grab && !done_now)
      |=> s_held)
      else $error("Grab during slave ownership not held.");
   a_release_end: assert property (
      (done_now && enable && !end_grab_shortcut && !grab_pend_r && !task_grab)
      |=> sem_r == sss_pkg::SEM_FREE && transaction_done_event)
      else $error("Frame end did not free the semaphore.");
   a_shortcut_cpu: assert property (
      (done_now && enable && end_grab_shortcut) |=> s_served ##1
      !semaphore_granted_event)
      else $error("Shortcut did not serve exactly one grab.");
   a_ignore_fill: assert property (
      (ld_go && xfer_r == sss_pkg::XF_IGNORE)
      |=> tx_sh_r == $past(ignored_transaction_fill_char))
      else $error("Ignored frame did not send its fill.");
   a_overrun_fill: assert property (
      (ld_go && xfer_r == sss_pkg::XF_GRANT && !need_mem)
      |=> tx_sh_r == $past(overrun_fill_char))
      else $error("Byte past the limit did not carry fill.");
   a_tx_limit_exceeded_flag_flag: assert property (
      (smp_edge && bit_cnt_r == sss_pkg::BIT_FIRST && tx_fill_r
       && xfer_r == sss_pkg::XF_GRANT) |=> tx_limit_exceeded_flag)
      else $error("Clocked fill byte did not set over-read.");
   a_overflow_drop: assert property (
      (byte_done && xfer_r == sss_pkg::XF_GRANT && rx_cnt_r >= rx_lim_r)
      |=> rx_overflow_flag && $stable(rx_cnt_r))
      else $error("Excess byte not dropped with overflow.");
   a_miso_hiz: assert property (
      csn_q[1] |=> !miso_oe)
      else $error("Output driven while not selected.");
endmodule : sss_spi_slave

// File: dv/sss_master_model.sv
// Master model that drives select, clock and data into the slave.
// Assumes the bench has settled the mode inputs before each frame.
module sss_master_model (
   output logic csn,
   output logic sck,
   output logic mosi,
   input wire logic miso,
   input wire logic cpol,
   input wire logic cpha
);
   timeunit 1ns;
   timeprecision 1ns;
   // The clock stands at its idle level outside frames.
   initial
   begin
      csn = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   // Four bytes, MSB first, 160 ns clock; the lead-in covers the sync delay.
   // Pins move 3 ns after a clock edge so no change meets a sampling edge.
   task frame(input logic [31:0] tx, output logic [31:0] rx);
      int i;
      #3 sck = cpol;
      #100 csn = 1'b0;
      #300;
      for (i = 31; i >= 0; i--)
      begin
         if (!cpha) mosi = tx[i];
         #80 sck = ~cpol;
         if (cpha) mosi = tx[i];
         else rx = {rx[30:0], miso};
         #80 sck = cpol;
         if (cpha) rx = {rx[30:0], miso};
      end
      #200 csn = 1'b1;
      mosi = ~mosi; // A released line must not keep its last value.
      #500;
   endtask : frame
endmodule : sss_master_model

// File: dv/sss_spi_slave_tb.sv
// Self-checking bench for the serial slave unit and its buffer engine.
// Assumes the master model and a memory that answers in one cycle.
module sss_spi_slave_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, enable, cpol, cpha, shortcut, grab, give, clr;
   logic csn, sck, mosi, miso_o, miso_oe, cpu, gnt, done, full, ovf, ovr;
   logic rd_req, rd_v, wr_v, wr_rdy;
   logic [7:0] rd_d;
   logic [13:0] lim_rx, lim_tx, rx_cnt, tx_cnt;
   logic [31:0] rd_a, got;
   sss_pkg::sss_wr_t wr;
   sss_pkg::sss_wr_t wq[$];
   int err_total, n_compared, n_gnt, n_done, n_full, m;
   // Pointers and fill bytes are held fixed for the whole run.
   sss_spi_slave i_dut (.mclk, .rst, .enable, .cpol, .cpha,
      .end_grab_shortcut(shortcut), .task_grab(grab), .task_give(give),
      .rx_buffer_pointer(32'h0000_0200), .tx_buffer_pointer(32'h0000_0100),
      .rx_byte_limit(lim_rx), .tx_byte_limit(lim_tx),
      .overrun_fill_char(8'hC3), .ignored_transaction_fill_char(8'h5A),
      .clr_overflow(clr), .clr_tx_limit_exceeded_flag(clr), .csn, .sck, .mosi, .miso_o,
      .miso_oe, .sem_cpu_owned(cpu), .semaphore_granted_event(gnt),
      .transaction_done_event(done), .rx_buffer_full_event(full),
      .rx_overflow_flag(ovf), .tx_limit_exceeded_flag(ovr),
      .rx_bytes_written_count(rx_cnt), .tx_bytes_read_count(tx_cnt),
      .mem_rd_req(rd_req), .mem_rd_addr(rd_a), .mem_rd_valid(rd_v),
      .mem_rd_data(rd_d), .mem_wr_valid(wr_v), .mem_wr(wr),
      .mem_wr_ready(wr_rdy));
   sss_master_model i_mst (.csn, .sck, .mosi,
      .miso(miso_oe ? miso_o : 1'bz), .cpol, .cpha);
   always #5 mclk = ~mclk;
   // Memory and event tally; counting pulses avoids exact-cycle sampling.
   always @(posedge mclk)
   begin
      rd_v <= rd_req;
      rd_d <= rd_a[7:0] + 8'h30;
      if (wr_v && wr_rdy) wq.push_back(wr);
      if (gnt === 1'b1) n_gnt++;
      if (done === 1'b1) n_done++;
      if (full === 1'b1) n_full++;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task give_verdict();
      $display("Mismatches %0d, compares %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // One-cycle pulse on grab, give or flag clear, then settle time.
   task pulse(input logic [2:0] v);
      @(posedge mclk);
      {grab, give, clr} <= v;
      @(posedge mclk);
      {grab, give, clr} <= 3'h0;
      repeat (4) @(posedge mclk);
   endtask : pulse
   task wait_done(input int t);
      int k;
      for (k = 0; k < 300 && n_done < t; k++) @(posedge mclk);
      if (n_done < t)
      begin
         chk(32'h0, 32'h1);
         give_verdict();
      end
   endtask : wait_done
   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      {enable, cpol, cpha, shortcut, grab, give, clr} = 7'h00;
      wr_rdy = 1'b1;
      lim_rx = 14'h0003;
      lim_tx = 14'h0002;
      {err_total, n_compared, n_gnt, n_done, n_full} = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      enable <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({cpu, miso_oe, n_gnt[7:0]}, 10'h200);
      pulse(3'h4);
      chk(n_gnt, 1);
      // The give lands mid-frame; the frame must stay ignored to its end.
      fork
         i_mst.frame(32'hA1B2C3D4, got);
         begin
            #2000;
            pulse(3'h2);
         end
      join
      chk(got, 32'h5A5A5A5A);
      chk(n_done, 0);
      chk(wq.size(), 0);
      chk(cpu, 0);
      pulse(3'h2);
      chk({cpu, n_gnt[7:0]}, 9'h001);
      // Each clock mode in turn, with the write port stalled in one pass.
      for (m = 0; m < 4; m++)
      begin
         cpol <= m[1];
         cpha <= m[0];
         wr_rdy <= (m != 2);
         pulse(3'h1);
         wq.delete();
         i_mst.frame(32'hA1B2C3D4, got);
         chk(got, 32'h3031C3C3);
         if (m == 2)
         begin
            repeat (20) @(posedge mclk);
            chk(n_done, m);
            wr_rdy <= 1'b1;
         end
         wait_done(m + 1);
         repeat (3) @(posedge mclk);
         chk(wq.size(), 3);
         chk({wq[0].data, wq[1].data, wq[2].data}, 24'hA1B2C3);
         chk(wq[2].addr, 32'h0000_0202);
         chk({ovf, ovr, rx_cnt, tx_cnt}, {2'h3, 14'h3, 14'h2});
         chk({n_full[7:0], cpu, miso_oe}, {m[7:0] + 8'h1, 2'h0});
      end
      // A disable hands the semaphore to the processor without an event.
      enable <= 1'b0;
      repeat (3) @(posedge mclk);
      enable <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({cpu, n_gnt[7:0]}, 9'h101);
      pulse(3'h2);
      shortcut <= 1'b1;
      fork
         i_mst.frame(32'hA1B2C3D4, got);
         begin
            #2000;
            pulse(3'h2);
            pulse(3'h4);
            chk({cpu, n_gnt[7:0]}, 9'h001);
         end
      join
      wait_done(5);
      repeat (5) @(posedge mclk);
      chk({cpu, n_gnt[7:0]}, 9'h102);
      give_verdict();
   end
endmodule : sss_spi_slave_tb
